// ---- logic/pmc_addr_decode.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_addr_decode (
    input  wire logic [15:0] addr,
    input  wire logic        io,
    input  wire logic        chan_hi_jmp,
    input  wire logic [7:0]  chan_sw,
    input  wire logic [2:0]  sel_sw,
    output logic             mem_hit,
    output logic             ch_hit,
    output logic [3:0]       ch
);
    // switch ON reads as 1 here and stands for logic 0 on the bus
    always_comb begin
        mem_hit = !io && (addr[15:13] == ~sel_sw);
        ch_hit  = io && (addr[15:13] == `PMC_IO_TOP)
               && (addr[12] == chan_hi_jmp)
               && (addr[11:4] == ~chan_sw);
        ch      = addr[3:0];
    end
endmodule : pmc_addr_decode
`default_nettype wire

// ---- logic/pmc_bus_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface pmc_bus_if;
    logic [15:0] addr;
    logic        bov;     // bus operation valid
    logic        wr;      // 1 write, 0 read
    logic        io;      // register area access
    logic        word;    // 16-bit transfer
    logic [15:0] m_dout;
    logic        m_doe;
    logic [15:0] c_dout;
    logic        c_doe;
    logic        rdy;
    logic [15:0] d;       // resolved data lines

    // whichever end drives owns the lines; idle lines read zero
    assign d = c_doe ? c_dout : (m_doe ? m_dout : 16'h0000);

    modport card (
        input  addr, bov, wr, io, word, d,
        output c_dout, c_doe, rdy
    );
    modport master (
        output addr, bov, wr, io, word, m_dout, m_doe,
        input  d, rdy
    );
endinterface : pmc_bus_if
`default_nettype wire

// ---- logic/pmc_card.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_card #(
    parameter bit HAS_ECC = 1'b1
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       act_src_jmp,
    input  wire logic       chan_hi_jmp,
    input  wire logic [7:0] chan_sw,
    input  wire logic [2:0] sel_sw,
    pmc_bus_if.card         bus
);
    localparam int DEPTH = 1 << (`PMC_PAGE_W + 12);
    localparam logic [5:0] LAT = 6'(`PMC_CARD_LAT_CYC - 1);

    //--------------------------------------------------
    // state and storage
    //--------------------------------------------------
    pmc_pkg::pmc_card_s s_reg;
    pmc_pkg::pmc_card_s s_next;
    logic [15:0] mem [DEPTH];
    // one saving sign per word stands in for the check bits;
    // two-state so a never stamped word reads as unsigned, not unknown
    bit          sign [DEPTH];

    logic        mem_hit;
    logic        ch_hit;
    logic [3:0]  ch;
    logic        active;
    logic        ch_ok;
    logic        hit;
    logic [15:0] widx;
    logic [15:0] rword;
    logic        rsign;
    logic        fmt_mode;
    logic        lane_lo;
    logic        lane_hi;
    logic        mem_we;
    logic [15:0] mem_wd;
    logic [1:0]  mem_be;
    logic        err_set;
    logic        err_clr;
    logic [15:0] basic;

    //--------------------------------------------------
    // decode
    //--------------------------------------------------
    pmc_addr_decode u_dec (
        .addr        (bus.addr),
        .io          (bus.io),
        .chan_hi_jmp (chan_hi_jmp),
        .chan_sw     (chan_sw),
        .sel_sw      (sel_sw),
        .mem_hit     (mem_hit),
        .ch_hit      (ch_hit),
        .ch          (ch)
    );

    // effective activity and what counts as ours
    always_comb begin
        active = !act_src_jmp || s_reg.act;
        ch_ok  = ch_hit && (ch == `PMC_CH_PAGE || ch == `PMC_CH_ERR
                 || ch == `PMC_CH_ACT);
        hit    = ch_ok || (mem_hit && active);
    end

    // word index inside the window and byte lanes
    always_comb begin
        widx     = {s_reg.page, bus.addr[12:1]};
        lane_lo  = bus.word || !bus.addr[0];
        lane_hi  = bus.word || bus.addr[0];
        fmt_mode = HAS_ECC && !s_reg.fmt;
        rword    = mem[widx];
        rsign    = sign[widx];
    end

    // register image seen on every channel read
    always_comb begin
        basic = 16'h0000;
        basic[`PMC_PAGE_LSB +: `PMC_PAGE_W] = s_reg.page;
        basic[`PMC_BIT_FMT]   = s_reg.fmt;
        basic[`PMC_BIT_SPARE] = s_reg.spare;
        basic[`PMC_BIT_ERR]   = HAS_ECC && s_reg.err;
        basic[`PMC_BIT_ACT]   = active;
    end

    //--------------------------------------------------
    // next state
    //--------------------------------------------------
    always_comb begin
        s_next  = s_reg;
        mem_we  = 1'b0;
        mem_wd  = 16'h0000;
        mem_be  = 2'b00;
        err_set = 1'b0;
        err_clr = 1'b0;
        unique case (s_reg.st)
            pmc_pkg::C_IDLE: begin
                // sluggish answer mimics the real access time
                if (bus.bov && hit) begin
                    s_next.st  = pmc_pkg::C_WAIT;
                    s_next.cnt = LAT;
                end
            end
            pmc_pkg::C_WAIT: begin
                if (!bus.bov) begin
                    s_next.st = pmc_pkg::C_IDLE;
                end else if (s_reg.cnt != 6'h00) begin
                    s_next.cnt = s_reg.cnt - 6'h01;
                end else begin
                    s_next.st  = pmc_pkg::C_DONE;
                    s_next.rdy = 1'b1;
                    if (ch_ok) begin
                        if (bus.wr) begin
                            unique case (ch)
                                `PMC_CH_PAGE: begin
                                    s_next.page = bus.d[`PMC_PAGE_LSB +: `PMC_PAGE_W];
                                    s_next.fmt   = bus.d[`PMC_BIT_FMT];
                                    s_next.spare = bus.d[`PMC_BIT_SPARE];
                                end
                                `PMC_CH_ERR: begin
                                    err_clr = 1'b1;
                                end
                                `PMC_CH_ACT: begin
                                    s_next.act = bus.d[`PMC_BIT_ACT];
                                end
                                default: begin
                                    s_next.act = s_reg.act;
                                end
                            endcase
                        end else begin
                            s_next.doe  = 1'b1;
                            s_next.dout = basic;
                        end
                    end else if (fmt_mode) begin
                        // any touch formats the word to zero
                        mem_we = 1'b1;
                        mem_be = 2'b11;
                        mem_wd = 16'h0000;
                        if (!bus.wr) begin
                            s_next.doe  = 1'b1;
                            s_next.dout = 16'h0000;
                        end
                    end else if (bus.wr) begin
                        mem_we = 1'b1;
                        mem_be = {lane_hi, lane_lo};
                        mem_wd = bus.d;
                    end else begin
                        s_next.doe  = 1'b1;
                        s_next.dout = rword;
                        // a word never stamped cannot be trusted
                        err_set = HAS_ECC && !rsign;
                    end
                end
            end
            pmc_pkg::C_DONE: begin
                // hold the answer until the master lets go
                if (!bus.bov) begin
                    s_next.st   = pmc_pkg::C_IDLE;
                    s_next.rdy  = 1'b0;
                    s_next.doe  = 1'b0;
                    s_next.dout = 16'h0000;
                end
            end
            default: begin
                s_next.st = pmc_pkg::C_IDLE;
            end
        endcase
        // a fresh error beats a simultaneous acknowledge
        s_next.err = HAS_ECC && (err_set || (s_reg.err && !err_clr));
    end

    //--------------------------------------------------
    // registers
    //--------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_reg       <= '0;
            s_reg.st    <= pmc_pkg::C_IDLE;
            s_reg.page  <= `PMC_PAGE_RST;
            s_reg.fmt   <= `PMC_FMT_RST;
            s_reg.act   <= `PMC_ACT_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // storage has no reset: contents survive on battery
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            if (mem_be[0]) begin
                mem[widx][7:0] <= mem_wd[7:0];
            end
            if (mem_be[1]) begin
                mem[widx][15:8] <= mem_wd[15:8];
            end
            sign[widx] <= 1'b1;
        end
    end

    assign bus.rdy    = s_reg.rdy;
    assign bus.c_doe  = s_reg.doe;
    assign bus.c_dout = s_reg.dout;
endmodule : pmc_card
`default_nettype wire

// ---- logic/pmc_consts.svh ----
// Behaviour
// - factory jumper: active after reset, else flag
// - channel 4 write sets active flag D0
// - error flag only on correcting variants
// - uncorrectable access sets error flag, sticky
// - any write to channel 2 clears error
// - format bit 0 formats, 1 saves; formats only when HAS_ECC is set
// - master writes channel 0 to format page
// - format by touching every window location
// - formatted locations read back as zero
// - master formats all pages before use; tb formats two words of page 1 only and reads page 2 unformatted
// - master restores saving mode, clears error
// - upper data byte ignored on register write
// - channel decode from jumper and switch
// - per-channel writable bits, rest read-only
// - window decode A15..A13 versus select switch
// - A12..A0 address inside selected page
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
`define PMC_CLK_NS        8
`define PMC_CARD_LAT_NS   200
`define PMC_CARD_LAT_CYC  ((`PMC_CARD_LAT_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_TMO_NS        2000
`define PMC_TMO_CYC       (`PMC_TMO_NS / `PMC_CLK_NS)
`define PMC_BIT_ACT       0
`define PMC_BIT_ERR       1
`define PMC_BIT_SPARE     2
`define PMC_BIT_FMT       3
`define PMC_PAGE_LSB      4
`define PMC_PAGE_W        4
`define PMC_CH_PAGE       4'h0
`define PMC_CH_ERR        4'h2
`define PMC_CH_ACT        4'h4
`define PMC_IO_TOP        3'h7
`define PMC_FMT_RST       1'b1
`define PMC_PAGE_RST      4'h0
`define PMC_ACT_RST       1'b0
`define PMC_R_ADDR        4'h0
`define PMC_R_WDATA       4'h1
`define PMC_R_CTRL        4'h2
`define PMC_R_RDATA       4'h3
`define PMC_R_STAT        4'h4
`define PMC_R_MASK        4'h5
`define PMC_C_GO          0
`define PMC_C_WR          1
`define PMC_C_IO          2
`define PMC_C_WORD        3
`define PMC_S_BUSY        0
`define PMC_S_DONE        1
`define PMC_S_TMO         2
`endif

// ---- logic/pmc_master.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_master (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    output logic             irq,
    pmc_bus_if.master        bus
);
    localparam logic [8:0] TMO = 9'(`PMC_TMO_CYC - 1);

    pmc_pkg::pmc_host_s h_reg;
    pmc_pkg::pmc_host_s h_next;
    logic [2:0] ev;

    //--------------------------------------------------
    // register port and bus cycle sequencer
    //--------------------------------------------------
    always_comb begin
        h_next = h_reg;
        ev     = 3'b000;
        unique case (h_reg.st)
            pmc_pkg::H_IDLE: begin
                if (reg_wr && reg_addr == `PMC_R_CTRL && reg_wdata[`PMC_C_GO]) begin
                    h_next.st   = pmc_pkg::H_WAIT;
                    h_next.wr   = reg_wdata[`PMC_C_WR];
                    h_next.io   = reg_wdata[`PMC_C_IO];
                    h_next.word = reg_wdata[`PMC_C_WORD];
                    h_next.bov  = 1'b1;
                    h_next.doe  = reg_wdata[`PMC_C_WR];
                    h_next.cnt  = TMO;
                end
            end
            pmc_pkg::H_WAIT: begin
                // an unclaimed address must not hang the master
                if (bus.rdy) begin
                    h_next.rd_val = bus.d;
                    h_next.bov    = 1'b0;
                    h_next.doe    = 1'b0;
                    h_next.st     = pmc_pkg::H_REL;
                    ev[`PMC_S_DONE] = 1'b1;
                end else if (h_reg.cnt == 9'h000) begin
                    h_next.bov = 1'b0;
                    h_next.doe = 1'b0;
                    h_next.st  = pmc_pkg::H_REL;
                    ev[`PMC_S_TMO] = 1'b1;
                end else begin
                    h_next.cnt = h_reg.cnt - 9'h001;
                end
            end
            pmc_pkg::H_REL: begin
                // wait for the card to drop ready before reuse
                if (!bus.rdy) begin
                    h_next.st = pmc_pkg::H_IDLE;
                end
            end
            default: begin
                h_next.st = pmc_pkg::H_IDLE;
            end
        endcase
        if (reg_wr && h_reg.st == pmc_pkg::H_IDLE) begin
            if (reg_addr == `PMC_R_ADDR) begin
                h_next.addr = reg_wdata;
            end
            if (reg_addr == `PMC_R_WDATA) begin
                h_next.wdata = reg_wdata;
            end
        end
        if (reg_wr && reg_addr == `PMC_R_MASK) begin
            h_next.mask = reg_wdata[2:0];
        end
        // status: busy is live, events sticky, set beats clear
        h_next.stat[`PMC_S_BUSY] = (h_next.st != pmc_pkg::H_IDLE);
        for (int i = 1; i < 3; i++) begin
            h_next.stat[i] = ev[i] || (h_reg.stat[i]
                && !(reg_wr && reg_addr == `PMC_R_STAT && reg_wdata[i]));
        end
        h_next.irq = |(h_next.stat[2:1] & h_next.mask[2:1]);
        // read data one cycle after the strobe, else zero
        h_next.rdata = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                `PMC_R_ADDR:  h_next.rdata = h_reg.addr;
                `PMC_R_WDATA: h_next.rdata = h_reg.wdata;
                `PMC_R_RDATA: h_next.rdata = h_reg.rd_val;
                `PMC_R_STAT:  h_next.rdata = {13'h0000, h_reg.stat};
                `PMC_R_MASK:  h_next.rdata = {13'h0000, h_reg.mask};
                default:      h_next.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            h_reg    <= '0;
            h_reg.st <= pmc_pkg::H_IDLE;
        end else begin
            h_reg <= h_next;
        end
    end

    assign reg_rdata  = h_reg.rdata;
    assign irq        = h_reg.irq;
    assign bus.addr   = h_reg.addr;
    assign bus.bov    = h_reg.bov;
    assign bus.wr     = h_reg.wr;
    assign bus.io     = h_reg.io;
    assign bus.word   = h_reg.word;
    assign bus.m_dout = h_reg.wdata;
    assign bus.m_doe  = h_reg.doe;
endmodule : pmc_master
`default_nettype wire

// ---- logic/pmc_pkg.sv ----
`default_nettype none
`include "pmc_consts.svh"
package pmc_pkg;
    typedef enum logic [1:0] {C_IDLE, C_WAIT, C_DONE} pmc_card_e;
    typedef enum logic [1:0] {H_IDLE, H_WAIT, H_REL} pmc_host_e;

    typedef struct packed {
        pmc_card_e              st;
        logic [5:0]             cnt;
        logic [`PMC_PAGE_W-1:0] page;
        logic                   fmt;
        logic                   spare;
        logic                   err;
        logic                   act;
        logic                   rdy;
        logic                   doe;
        logic [15:0]            dout;
    } pmc_card_s;

    typedef struct packed {
        pmc_host_e   st;
        logic [8:0]  cnt;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        io;
        logic        word;
        logic [15:0] rd_val;
        logic [2:0]  stat;
        logic [2:0]  mask;
        logic        irq;
        logic [15:0] rdata;
        logic        bov;
        logic        doe;
    } pmc_host_s;
endpackage : pmc_pkg
`default_nettype wire

// ---- tb/pmc_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module pmc_chk #(
    parameter logic [2:0]  WIN_SEL = 3'h3,
    parameter logic [11:0] CH_TOP  = 12'hF2A
) (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic [15:0] addr,
    input wire logic        bov,
    input wire logic        wr,
    input wire logic        io,
    input wire logic        word,
    input wire logic        m_doe,
    input wire logic        c_doe,
    input wire logic        rdy
);
    // ------------------------------------------------------------
    // handshake on the card bus
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    // card lets go of ready and data together
    sequence s_release;
        !rdy && !c_doe;
    endsequence
    // master has fetched its answer and let go
    sequence s_taken;
        !bov ##1 s_release;
    endsequence

    property p_latency;
        $rose(rdy) |-> $past(bov, 26) && !$past(bov, 27);
    endproperty
    a_latency : assert property (p_latency) else $error("ready not 26 edges after cycle start");

    property p_hold;
        bov && rdy |=> rdy;
    endproperty
    a_hold : assert property (p_hold) else $error("ready dropped while cycle valid");

    property p_close;
        $rose(rdy) |=> s_taken;
    endproperty
    a_close : assert property (p_close) else $error("cycle not closed after ready");

    property p_drive;
        bov && rdy |-> c_doe == !wr;
    endproperty
    a_drive : assert property (p_drive) else $error("card data drive wrong for direction");

    property p_no_clash;
        !(c_doe && m_doe);
    endproperty
    a_no_clash : assert property (p_no_clash) else $error("both ends drive data");

    property p_stable;
        bov && $past(bov) |-> $stable(addr) && $stable(wr) && $stable(io) && $stable(word);
    endproperty
    a_stable : assert property (p_stable) else $error("request changed inside a cycle");

    property p_wdata;
        bov && wr |-> m_doe;
    endproperty
    a_wdata : assert property (p_wdata) else $error("write without master data");

    property p_win;
        $rose(rdy) && !io |-> addr[15:13] == WIN_SEL;
    endproperty
    a_win : assert property (p_win) else $error("answered outside its window");

    property p_chan;
        $rose(rdy) && io |-> addr[15:4] == CH_TOP && addr[3:0] inside {4'h0, 4'h2, 4'h4};
    endproperty
    a_chan : assert property (p_chan) else $error("answered a foreign channel");
endmodule : pmc_chk
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pmc_consts.svh"
module tb;
    localparam logic [15:0] CH  = 16'hF2A0;
    localparam logic [15:0] WIN = 16'h6000;
    localparam logic [3:0]  RD  = 4'h9;
    localparam logic [3:0]  WR  = 4'hB;
    localparam logic [3:0]  IRD = 4'hD;
    localparam logic [3:0]  IWR = 4'hF;
    localparam logic [15:0] BAD [3] = '{16'hF2A1, 16'hE2A0, 16'h4000};
    logic        mclk      = 1'b0;
    logic        reset     = 1'b1;
    logic        act_jmp   = 1'b1;
    logic [3:0]  reg_addr  = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [15:0] reg_rdata;
    logic        irq;
    logic [15:0] rd;
    logic [15:0] st;
    int          miscompares = 0;
    int          comparisons = 0;

    // ------------------------------------------------------------
    // the two ends and the watcher between them
    // ------------------------------------------------------------
    pmc_bus_if bus ();
    // switches fixed: channel F2A0, window 6000
    pmc_card i_pmc_card (.mclk(mclk), .reset(reset), .act_src_jmp(act_jmp), .chan_hi_jmp(1'b1),
                         .chan_sw(8'hD5), .sel_sw(3'b100), .bus(bus));
    pmc_master i_pmc_master (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                             .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .bus(bus));
    pmc_chk i_pmc_chk (.mclk(mclk), .reset(reset), .addr(bus.addr), .bov(bus.bov), .wr(bus.wr),
                       .io(bus.io), .word(bus.word), .m_doe(bus.m_doe), .c_doe(bus.c_doe), .rdy(bus.rdy));

    // free running 125 MHz
    always #4 mclk = ~mclk;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // strobe is lowered on the next edge, so calls never collide
    task automatic rwr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : rwr

    task automatic rrd(input logic [3:0] a, output logic [15:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rrd

    // one bus transfer, status left pending for irq tests
    task automatic xfer(input logic [15:0] a, input logic [15:0] v, input logic [3:0] ctl, input bit ok);
        int n;
        rwr(`PMC_R_STAT, 16'h0006);
        rwr(`PMC_R_ADDR, a);
        rwr(`PMC_R_WDATA, v);
        rwr(`PMC_R_CTRL, {12'h000, ctl});
        n  = 0;
        st = 16'h0001;
        while (st[`PMC_S_BUSY] !== 1'b0 && n < 400) begin
            rrd(`PMC_R_STAT, st);
            n++;
        end
        rrd(`PMC_R_RDATA, rd);
        if (ok) begin
            check("status done", st & 16'h0007, 16'h0002);
        end else begin
            check("status timeout", st & 16'h0005, 16'h0004);
        end
    endtask : xfer

    task automatic reg_is(input logic [15:0] exp);
        xfer(CH, 16'h0000, IRD, 1'b1);
        check("basic register", rd, exp);
    endtask : reg_is

    task automatic wait_irq(input logic exp);
        repeat (2) @(posedge mclk);
        #1;
        check("irq", {15'h0000, irq}, {15'h0000, exp});
    endtask : wait_irq

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // bus flag source: inactive after reset, window silent, irq path
    task automatic t_inactive;
        reg_is(16'h0008);
        xfer(WIN, 16'h0000, RD, 1'b0);
        wait_irq(1'b0);
        rwr(`PMC_R_MASK, 16'h0006);
        wait_irq(1'b1);
        rwr(`PMC_R_STAT, 16'h0006);
        wait_irq(1'b0);
    endtask : t_inactive

    // only bit 0 takes on channel 4, then foreign addresses go unanswered
    task automatic t_active;
        xfer(CH + 16'h0004, 16'hFFFE, IWR, 1'b1);
        reg_is(16'h0008);
        xfer(CH + 16'h0004, 16'h0001, IWR, 1'b1);
        reg_is(16'h0009);
        for (int i = 0; i < 3; i++) begin
            xfer(BAD[i], 16'h0000, (BAD[i][15:13] == 3'h7) ? IRD : RD, 1'b0);
        end
    endtask : t_active

    // format page 1, back to saving, then error on untouched page 2
    task automatic t_format;
        xfer(CH, 16'hFF13, IWR, 1'b1);
        reg_is(16'h0011);
        xfer(WIN + 16'h0002, 16'h1234, WR, 1'b1);
        xfer(WIN + 16'h0002, 16'h0000, RD, 1'b1);
        check("formatted word", rd, 16'h0000);
        xfer(WIN + 16'h0004, 16'h0000, RD, 1'b1);
        xfer(CH, 16'h0018, IWR, 1'b1);
        xfer(WIN + 16'h0004, 16'h0000, RD, 1'b1);
        check("formatted word", rd, 16'h0000);
        reg_is(16'h0019);
        xfer(WIN + 16'h0002, 16'hA5C3, WR, 1'b1);
        xfer(WIN + 16'h0002, 16'h0000, RD, 1'b1);
        check("stored word", rd, 16'hA5C3);
        xfer(CH, 16'h0028, IWR, 1'b1);
        xfer(WIN + 16'h0002, 16'h0000, RD, 1'b1);
        reg_is(16'h002B);
        xfer(CH, 16'h0018, IWR, 1'b1);
        reg_is(16'h001B);
        xfer(CH + 16'h0002, 16'hFFFF, IWR, 1'b1);
        reg_is(16'h0019);
    endtask : t_format

    // factory jumper overrides a cleared flag
    task automatic t_factory;
        xfer(CH + 16'h0004, 16'h0000, IWR, 1'b1);
        reg_is(16'h0018);
        @(posedge mclk);
        act_jmp <= 1'b0;
        reg_is(16'h0019);
        xfer(WIN + 16'h0002, 16'h0000, RD, 1'b1);
        check("page 1 word", rd, 16'hA5C3);
        @(posedge mclk);
        act_jmp <= 1'b1;
        xfer(WIN + 16'h0002, 16'h0000, RD, 1'b0);
    endtask : t_factory

    // ------------------------------------------------------------
    // sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // main sequence after 20 reset cycles
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        t_inactive();
        t_active();
        t_format();
        t_factory();
        results();
    end

    // the whole run needs well under 20000 cycles
    initial begin
        repeat (40000) @(posedge mclk);
        miscompares++;
        results();
    end
endmodule : tb
`default_nettype wire
